/* File: logic/fbrio_pkg.sv */
// Notes on behaviour
// RULE1: Input byte 4 holds current fragment index.
// RULE2: Input byte 5 holds fragments still to follow.
// RULE3: Input byte 6 holds current fragment size.
// RULE4: Zero-length configuration means defaults everywhere.
// RULE5: No acknowledge handshake with empty configuration.
// RULE6: Output 1 follows the activation request bit.
// RULE7: Output 2 shows decode valid, low on failure.
// RULE8: Output byte 1 activation needs external mode.
// RULE9: Non-external outputs ignore activation request bits.
// RULE10: Each toggle bit inverts once per event.
// RULE11: Controller keeps reserved output bits zero.
package fbrio_pkg;

  // ----------------------------------------------------------------
  // Input image byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_DEV_STATE = 5'h00;
  localparam logic [4:0] OFS_IO_LOW = 5'h01;
  localparam logic [4:0] OFS_IO_HIGH = 5'h02;
  localparam logic [4:0] OFS_XFER = 5'h03;
  localparam logic [4:0] OFS_FRAG_IDX = 5'h04;
  localparam logic [4:0] OFS_FRAG_LEFT = 5'h05;
  localparam logic [4:0] OFS_FRAG_LEN = 5'h06;
  localparam logic [4:0] OFS_RES_COUNT = 5'h07;
  localparam logic [4:0] OFS_RES_FLAGS = 5'h08;
  localparam logic [4:0] OFS_LEN_LOW = 5'h09;
  localparam logic [4:0] OFS_LEN_HIGH = 5'h0A;
  localparam logic [4:0] OFS_PAY_FIRST = 5'h0B;
  localparam logic [4:0] OFS_PAY_LAST = 5'h15;

  // ----------------------------------------------------------------
  // Control request byte fields and masks, result flag bits
  // ----------------------------------------------------------------
  localparam int CTL_ACT_BIT = 0;
  localparam int CTL_DRST_BIT = 2;
  localparam int CTL_STBY_BIT = 4;
  localparam logic [7:0] CTL_USED_MASK = 8'h1F;
  localparam int FLAG_WAIT_BIT = 5;
  localparam int FLAG_NEW_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values and defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [3:0] DEF_EXT_MASK = 4'h0;
  localparam logic [7:0] FRAG_MAX = 8'h0B;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int FRAG_HOLD_NS = 10000;
  localparam logic [7:0] FRAG_HOLD_CYC = 8'((FRAG_HOLD_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Fragment sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_HOLD = 3'b100
  } fbrio_state_t;

endpackage

/* File: logic/fbrio_fifo.sv */
`timescale 1ns/10ps
module fbrio_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  // Pointers need a power of two so that wrap is free.
  if (D < 2 || (D & (D - 1)) != 0 || W < 1) begin : g_bad_depth
    $error("fbrio_fifo needs a power of two depth and a nonzero width");
  end

  logic [W-1:0] mem_r [D];
  logic [W-1:0] mem_nxt [D];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  // ------------------------------------------------------------------
  // Flags and next pointers
  // ------------------------------------------------------------------
  // The extra pointer bit tells full from empty without a counter.
  assign in_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_r != rp_r;
  assign out_data = mem_r[rp_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state of storage and pointers.
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      mem_nxt[wp_r[AW-1:0]] = in_data;
      wp_nxt = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
  end

  // Storage has no reset; only the pointers must start defined.
  always_ff @(posedge sys_clk) begin
    mem_r <= mem_nxt;
  end

  // Pointer registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

endmodule

/* File: logic/fbrio_image.sv */
`timescale 1ns/10ps
module fbrio_image #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Output image from the controller
  input wire logic ctl_we,
  input wire logic [7:0] ctl_byte0,
  input wire logic [7:0] ctl_byte1,
  // Configuration image
  input wire logic [7:0] cfg_len,
  input wire logic [3:0] cfg_ext_mask,
  // Input image read port
  input wire logic [4:0] img_addr,
  output logic [7:0] img_data,
  // Result descriptor from the decoder
  input wire logic hdr_valid,
  output logic hdr_ready,
  input wire logic [15:0] hdr_len,
  input wire logic hdr_failed_decode_result,
  // Result bytes from the decoder
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data,
  // Comparison states and switching outputs
  input wire logic [3:0] cmp_state,
  output logic [3:0] sw_out
);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fbrio_image needs a FIFO of at least two words");
  end

  // ------------------------------------------------------------------
  // Result byte buffer
  // ------------------------------------------------------------------
  logic f_valid, f_pop;
  logic [7:0] f_data;

  fbrio_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(byte_valid),
    .in_ready(byte_ready),
    .in_data(byte_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // ------------------------------------------------------------------
  // Controller request state
  // ------------------------------------------------------------------
  logic [7:0] ctl0_r, ctl0_nxt, ctl1_r, ctl1_nxt;
  logic acc_r, acc_nxt, rej_r, rej_nxt, ovf_r, ovf_nxt;
  logic [3:0] sw_r, sw_nxt, cmp_r, cmp_nxt, ctog_r, ctog_nxt, ext_eff;
  logic valid_r, drst, stby;

  // An empty configuration image forces the default output functions.
  assign ext_eff = (cfg_len == 8'h00) ? fbrio_pkg::DEF_EXT_MASK : cfg_ext_mask; // [RULE4]
  assign drst = ctl0_r[fbrio_pkg::CTL_DRST_BIT];
  assign stby = ctl0_r[fbrio_pkg::CTL_STBY_BIT];

  // A request image with reserved bits set is refused whole and flagged.
  // Acknowledge bits are stored but never acted on: no acknowledge mode.
  always_comb begin
    ctl0_nxt = ctl0_r;
    ctl1_nxt = ctl1_r;
    acc_nxt = acc_r;
    rej_nxt = rej_r;
    if (ctl_we) begin
      if ((ctl_byte0 & ~fbrio_pkg::CTL_USED_MASK) != 8'h00) begin
        rej_nxt = ~rej_r; // [RULE10]
      end else begin
        ctl0_nxt = ctl_byte0;
        ctl1_nxt = ctl_byte1;
        acc_nxt = ~acc_r; // [RULE10]
      end
    end
    cmp_nxt = cmp_state;
    ctog_nxt = ctog_r ^ (cmp_state ^ cmp_r); // [RULE10]
    // Set wins over the data reset clear.
    ovf_nxt = (ovf_r && !drst) || (byte_valid && !byte_ready);
  end

  // Outputs 1 and 2 run their own function and outputs 3..4 stay low, unless set to external activation.
  for (genvar k = 0; k < 4; k++) begin : g_sw
    always_comb begin
      if (ext_eff[k]) begin
        sw_nxt[k] = ctl1_nxt[2*k]; // [RULE8] [RULE9]
      end else if (k == 0) begin
        sw_nxt[k] = ctl0_nxt[fbrio_pkg::CTL_ACT_BIT]; // [RULE6]
      end else if (k == 1) begin
        sw_nxt[k] = valid_r; // [RULE7]
      end else begin
        sw_nxt[k] = 1'b0; // [RULE9]
      end
    end
  end

  // Request registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl0_r <= fbrio_pkg::CTL_RESET;
      ctl1_r <= fbrio_pkg::CTL_RESET;
      acc_r <= 1'b0;
      rej_r <= 1'b0;
      ovf_r <= 1'b0;
      sw_r <= 4'h0;
      cmp_r <= 4'h0;
      ctog_r <= 4'h0;
    end else begin
      ctl0_r <= ctl0_nxt;
      ctl1_r <= ctl1_nxt;
      acc_r <= acc_nxt;
      rej_r <= rej_nxt;
      ovf_r <= ovf_nxt;
      sw_r <= sw_nxt;
      cmp_r <= cmp_nxt;
      ctog_r <= ctog_nxt;
    end
  end

  assign sw_out = sw_r;

  // ------------------------------------------------------------------
  // Fragment sequencer
  // ------------------------------------------------------------------
  fbrio_pkg::fbrio_state_t st_r, st_nxt;
  logic [15:0] remain_r, remain_nxt, len_r, len_nxt, rest;
  logic [7:0] tgt_r, tgt_nxt, fill_r, fill_nxt, hold_r, hold_nxt;
  logic [7:0] idx_r, idx_nxt, fidx_r, fidx_nxt, fleft_r, fleft_nxt;
  logic [7:0] fsize_r, fsize_nxt, cnt_r, cnt_nxt;
  logic [7:0] buf_r [11];
  logic [7:0] buf_nxt [11];
  logic newtog_r, newtog_nxt, valid_nxt, failed_decode_result_r, failed_decode_result_nxt, publish;

  // Size of the next fragment: at most eleven bytes.
  function automatic logic [7:0] frag_of(input logic [15:0] left);
    frag_of = (left > 16'(fbrio_pkg::FRAG_MAX)) ? fbrio_pkg::FRAG_MAX : left[7:0];
  endfunction

  assign rest = remain_r - 16'(tgt_r);

  // Without acknowledge mode each fragment is simply held for a fixed time.
  // The payload bytes change while the next fragment fills, so the
  // controller must take a fragment on the new-result toggle.
  always_comb begin
    st_nxt = st_r;
    remain_nxt = remain_r;
    len_nxt = len_r;
    tgt_nxt = tgt_r;
    fill_nxt = fill_r;
    hold_nxt = hold_r;
    idx_nxt = idx_r;
    fidx_nxt = fidx_r;
    fleft_nxt = fleft_r;
    fsize_nxt = fsize_r;
    newtog_nxt = newtog_r;
    valid_nxt = valid_r;
    failed_decode_result_nxt = failed_decode_result_r;
    buf_nxt = buf_r;
    cnt_nxt = drst ? 8'h00 : cnt_r;
    hdr_ready = 1'b0;
    f_pop = 1'b0;
    publish = 1'b0;
    case (st_r)
      fbrio_pkg::ST_IDLE: begin
        if (!stby) begin
          hdr_ready = 1'b1;
          if (hdr_valid) begin
            remain_nxt = hdr_failed_decode_result ? 16'h0000 : hdr_len;
            len_nxt = hdr_failed_decode_result ? 16'h0000 : hdr_len;
            failed_decode_result_nxt = hdr_failed_decode_result;
            tgt_nxt = hdr_failed_decode_result ? 8'h00 : frag_of(hdr_len);
            fill_nxt = 8'h00;
            idx_nxt = 8'h00;
            cnt_nxt = (cnt_r == 8'hFF) ? cnt_r : cnt_r + 8'h01;
            st_nxt = fbrio_pkg::ST_FILL;
          end
        end
      end
      fbrio_pkg::ST_FILL: begin
        if (fill_r == tgt_r) begin
          publish = 1'b1;
          fidx_nxt = idx_r; // [RULE1]
          fleft_nxt = 8'((rest + 16'h000A) / 16'h000B); // [RULE2]
          fsize_nxt = tgt_r; // [RULE3]
          remain_nxt = rest;
          newtog_nxt = ~newtog_r; // [RULE10]
          if (idx_r == 8'h00) begin
            valid_nxt = !failed_decode_result_r; // [RULE7]
          end
          hold_nxt = fbrio_pkg::FRAG_HOLD_CYC;
          st_nxt = fbrio_pkg::ST_HOLD; // [RULE5]
        end else if (!stby && f_valid) begin
          f_pop = 1'b1;
          buf_nxt[fill_r[3:0]] = f_data;
          fill_nxt = fill_r + 8'h01;
        end
      end
      fbrio_pkg::ST_HOLD: begin
        if (hold_r != 8'h00) begin
          hold_nxt = hold_r - 8'h01;
        end else if (remain_r == 16'h0000) begin
          st_nxt = fbrio_pkg::ST_IDLE;
        end else begin
          tgt_nxt = frag_of(remain_r);
          fill_nxt = 8'h00;
          idx_nxt = idx_r + 8'h01;
          st_nxt = fbrio_pkg::ST_FILL;
        end
      end
      default: begin
        st_nxt = fbrio_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= fbrio_pkg::ST_IDLE;
      remain_r <= 16'h0000;
      len_r <= 16'h0000;
      tgt_r <= 8'h00;
      fill_r <= 8'h00;
      hold_r <= 8'h00;
      idx_r <= 8'h00;
      fidx_r <= 8'h00;
      fleft_r <= 8'h00;
      fsize_r <= 8'h00;
      cnt_r <= 8'h00;
      newtog_r <= 1'b0;
      valid_r <= 1'b0;
      failed_decode_result_r <= 1'b0;
      for (int i = 0; i < 11; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else begin
      st_r <= st_nxt;
      remain_r <= remain_nxt;
      len_r <= len_nxt;
      tgt_r <= tgt_nxt;
      fill_r <= fill_nxt;
      hold_r <= hold_nxt;
      idx_r <= idx_nxt;
      fidx_r <= fidx_nxt;
      fleft_r <= fleft_nxt;
      fsize_r <= fsize_nxt;
      cnt_r <= cnt_nxt;
      newtog_r <= newtog_nxt;
      valid_r <= valid_nxt;
      failed_decode_result_r <= failed_decode_result_nxt;
      buf_r <= buf_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Input image read mux
  // ------------------------------------------------------------------
  logic [7:0] rd_nxt, rd_r;
  logic further;

  assign further = hdr_valid && (st_r != fbrio_pkg::ST_IDLE);

  // The waiting-for-acknowledge flag stays low: no acknowledge mode.
  always_comb begin
    if (img_addr == fbrio_pkg::OFS_DEV_STATE) begin
      rd_nxt = {7'h00, stby};
    end else if (img_addr == fbrio_pkg::OFS_IO_LOW) begin
      rd_nxt = {1'b0, ctog_r[1], cmp_r[1], sw_r[1], 1'b0, ctog_r[0], cmp_r[0], sw_r[0]};
    end else if (img_addr == fbrio_pkg::OFS_IO_HIGH) begin
      rd_nxt = {1'b0, ctog_r[3], cmp_r[3], sw_r[3], 1'b0, ctog_r[2], cmp_r[2], sw_r[2]};
    end else if (img_addr == fbrio_pkg::OFS_XFER) begin
      rd_nxt = {6'h00, rej_r, acc_r};
    end else if (img_addr == fbrio_pkg::OFS_FRAG_IDX) begin
      rd_nxt = fidx_r; // [RULE1]
    end else if (img_addr == fbrio_pkg::OFS_FRAG_LEFT) begin
      rd_nxt = fleft_r; // [RULE2]
    end else if (img_addr == fbrio_pkg::OFS_FRAG_LEN) begin
      rd_nxt = fsize_r; // [RULE3]
    end else if (img_addr == fbrio_pkg::OFS_RES_COUNT) begin
      rd_nxt = cnt_r;
    end else if (img_addr == fbrio_pkg::OFS_RES_FLAGS) begin
      rd_nxt = {3'h0, newtog_r, ovf_r, further, 1'b0, ctl0_r[fbrio_pkg::CTL_ACT_BIT]}; // [RULE5]
    end else if (img_addr == fbrio_pkg::OFS_LEN_LOW) begin
      rd_nxt = len_r[7:0];
    end else if (img_addr == fbrio_pkg::OFS_LEN_HIGH) begin
      rd_nxt = len_r[15:8];
    end else if (img_addr >= fbrio_pkg::OFS_PAY_FIRST && img_addr <= fbrio_pkg::OFS_PAY_LAST) begin
      rd_nxt = buf_r[4'(img_addr - fbrio_pkg::OFS_PAY_FIRST)];
    end else begin
      rd_nxt = 8'h00;
    end
  end

  // Read data register.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign img_data = rd_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_frag_idx;
    publish && idx_r != 8'h00 |=> fidx_r == $past(fidx_r) + 8'h01;
  endproperty
  a_frag_idx: assert property (p_frag_idx) else $error("fragment index not stepped"); // [RULE1]

  property p_frag_left;
    publish && remain_r <= 16'(fbrio_pkg::FRAG_MAX) |=> fleft_r == 8'h00;
  endproperty
  a_frag_left: assert property (p_frag_left) else $error("fragments left not zero"); // [RULE2]

  property p_frag_len;
    publish |=> fsize_r == $past(tgt_r) && fsize_r <= fbrio_pkg::FRAG_MAX;
  endproperty
  a_frag_len: assert property (p_frag_len) else $error("fragment size wrong"); // [RULE3]

  property p_default_cfg;
    cfg_len == 8'h00 && ctl_we |=> ##1 sw_out[3:2] == 2'b00;
  endproperty
  a_default_cfg: assert property (p_default_cfg) else $error("default outputs not kept"); // [RULE4]

  property p_no_ack;
    img_addr == fbrio_pkg::OFS_RES_FLAGS |=> !img_data[fbrio_pkg::FLAG_WAIT_BIT];
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("waiting for acknowledge set"); // [RULE5]

  property p_sw_act;
    !ext_eff[0] && ctl_we && ctl_byte0[7:5] == 3'h0 |=> sw_out[0] == $past(ctl_byte0[0]);
  endproperty
  a_sw_act: assert property (p_sw_act) else $error("output 1 not following activation"); // [RULE6]

  property p_sw_valid;
    publish && idx_r == 8'h00 && !ext_eff[1] |=> ##1 sw_out[1] == !$past(failed_decode_result_r, 2);
  endproperty
  a_sw_valid: assert property (p_sw_valid) else $error("output 2 not showing decode"); // [RULE7]

  property p_ext_only;
    !$past(ext_eff[2]) && !$past(ext_eff[3]) |-> sw_out[3:2] == 2'b00;
  endproperty
  a_ext_only: assert property (p_ext_only) else $error("activation bit used off mode"); // [RULE8] [RULE9]

  property p_toggle;
    publish |=> newtog_r != $past(newtog_r) ##1 newtog_r == $past(newtog_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("new result toggle wrong"); // [RULE10]

  c_publish: cover property (publish);
  c_multi: cover property (publish && idx_r == 8'h01);
  c_failed_decode_result: cover property (publish && failed_decode_result_r);
  c_ovf: cover property (ovf_r);

endmodule

/* File: tb/fbrio_ctl_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Controller model: writes the output image, reads the input image
// ----------------------------------------------------------------
module fbrio_ctl_model (
  // Clock
  input wire logic sys_clk,
  // Output and configuration image towards the device
  output logic ctl_we,
  output logic [7:0] ctl_byte0,
  output logic [7:0] ctl_byte1,
  output logic [7:0] cfg_len,
  output logic [3:0] cfg_ext_mask,
  // Input image read port
  output logic [4:0] img_addr,
  input wire logic [7:0] img_data
);
  // The configuration image is declared empty until a scenario asks otherwise.
  initial begin
    ctl_we = 1'b0;
    ctl_byte0 = 8'h00;
    ctl_byte1 = 8'h00;
    cfg_len = 8'h00;
    cfg_ext_mask = 4'h0;
    img_addr = 5'h00;
  end

  // Reserved bits are cleared unless a refusal is wanted on purpose.
  task automatic write_img(input logic [7:0] b0, input logic [7:0] b1, input bit raw);
    @(negedge sys_clk);
    ctl_we = 1'b1;
    ctl_byte0 = raw ? b0 : (b0 & fbrio_pkg::CTL_USED_MASK);
    ctl_byte1 = b1;
    @(negedge sys_clk);
    ctl_we = 1'b0;
  endtask

  // The data is registered, so it is taken one full cycle after the address.
  task automatic read_img(input logic [4:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    img_addr = a;
    @(negedge sys_clk);
    d = img_data;
  endtask

  // Configuration is a level; a change lands at the next falling edge.
  task automatic set_cfg(input logic [7:0] len, input logic [3:0] mask);
    @(negedge sys_clk);
    cfg_len = len;
    cfg_ext_mask = mask;
  endtask
endmodule

/* File: tb/fieldbus_result_io_image_tb.sv */
`timescale 1ns/10ps
module fieldbus_result_io_image_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ctl_we;
  logic [7:0] ctl_byte0, ctl_byte1, cfg_len, img_data;
  logic [3:0] cfg_ext_mask, sw_out;
  logic [3:0] cmp_state = 4'h0;
  logic [4:0] img_addr;
  logic hdr_valid = 1'b0;
  logic hdr_failed_decode_result = 1'b0;
  logic [15:0] hdr_len = 16'h0000;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic hdr_ready, byte_ready;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;

  fbrio_ctl_model u_fbrio_ctl_model (.sys_clk(sys_clk), .ctl_we(ctl_we),
    .ctl_byte0(ctl_byte0), .ctl_byte1(ctl_byte1), .cfg_len(cfg_len),
    .cfg_ext_mask(cfg_ext_mask), .img_addr(img_addr), .img_data(img_data));

  fbrio_image u_fbrio_image (.sys_clk(sys_clk), .nrst(nrst), .ctl_we(ctl_we),
    .ctl_byte0(ctl_byte0), .ctl_byte1(ctl_byte1), .cfg_len(cfg_len),
    .cfg_ext_mask(cfg_ext_mask), .img_addr(img_addr), .img_data(img_data),
    .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_len(hdr_len),
    .hdr_failed_decode_result(hdr_failed_decode_result), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .byte_data(byte_data), .cmp_state(cmp_state), .sw_out(sw_out));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  // The clock runs at 25 MHz.
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  // A hang is cut short well above the roughly one thousand cycles the run needs.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The stream byte is held until the FIFO shows room at the taking edge.
  task automatic push_byte(input logic [7:0] v);
    @(negedge sys_clk);
    byte_valid = 1'b1;
    byte_data = v;
    while (byte_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    byte_valid = 1'b0;
  endtask

  task automatic send_hdr(input logic [15:0] len, input logic nr);
    @(negedge sys_clk);
    hdr_valid = 1'b1;
    hdr_len = len;
    hdr_failed_decode_result = nr;
    while (hdr_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    hdr_valid = 1'b0;
  endtask

  // Publication is seen as a flip of the new-result toggle.
  task automatic wait_pub(inout logic tog);
    logic [7:0] d;
    int i;
    for (i = 0; i < 800; i++) begin
      u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_RES_FLAGS, d);
      if (d[fbrio_pkg::FLAG_NEW_BIT] !== tog) break;
    end
    check("new result toggle", d[fbrio_pkg::FLAG_NEW_BIT], !tog);
    check("waiting for ack", d[fbrio_pkg::FLAG_WAIT_BIT], 1'b0);
    tog = d[fbrio_pkg::FLAG_NEW_BIT];
  endtask

  task automatic check_frag(input logic [7:0] idx, input logic [7:0] left,
                            input logic [7:0] size, input logic [7:0] first);
    logic [7:0] d;
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_FRAG_IDX, d);
    check("fragment index", d, idx);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_FRAG_LEFT, d);
    check("fragments left", d, left);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_FRAG_LEN, d);
    check("fragment size", d, size);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_PAY_FIRST, d);
    if (size != 8'h00) check("payload first", d, first);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Output 1 without and outputs 3..4 with and without external mode, against activation bits.
  task automatic t_outputs();
    logic [7:0] d;
    u_fbrio_ctl_model.write_img(8'h01, 8'h55, 1'b0);
    check("sw_out 1", sw_out[0], 1'b1);
    check("sw_out 3..4 default", sw_out[3:2], 2'b00);
    u_fbrio_ctl_model.set_cfg(8'h01, 4'hC);
    u_fbrio_ctl_model.write_img(8'h00, 8'h50, 1'b0);
    check("sw_out 3..4 external", sw_out[3:2], 2'b11);
    check("sw_out 1 off", sw_out[0], 1'b0);
    u_fbrio_ctl_model.write_img(8'hE1, 8'h00, 1'b1);
    check("refused write keeps", sw_out, 4'hC);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_IO_HIGH, d);
    check("outputs 3 and 4 in image", d, 8'h11);
    // Two accepted writes flip acceptance back to 0, the refusal flips rejection once.
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_XFER, d);
    check("accept and reject toggles", d, 8'h02);
    u_fbrio_ctl_model.set_cfg(8'h00, 4'hC);
    u_fbrio_ctl_model.write_img(8'h00, 8'h50, 1'b0);
    check("mask unused when empty", sw_out[3:2], 2'b00);
  endtask

  // One change of a comparison state flips its toggle once only.
  task automatic t_cmp();
    logic [7:0] d0, d1;
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_IO_LOW, d0);
    @(negedge sys_clk);
    cmp_state = 4'h1;
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_IO_LOW, d1);
    check("compare 1 state and toggle", d1[2:1], {~d0[2], 1'b1});
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_IO_LOW, d1);
    check("compare 1 toggle once", d1[2], !d0[2]);
  endtask

  // A short result, then a failed decode.
  task automatic t_short(inout logic tog);
    logic [7:0] d;
    push_byte(8'hA5);
    push_byte(8'h3C);
    send_hdr(16'h0002, 1'b0);
    wait_pub(tog);
    check_frag(8'h00, 8'h00, 8'h02, 8'hA5);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_LEN_LOW, d);
    check("length low", d, 8'h02);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_LEN_HIGH, d);
    check("length high", d, 8'h00);
    check("valid decode output", sw_out[1], 1'b1);
    send_hdr(16'h0005, 1'b1);
    wait_pub(tog);
    check_frag(8'h00, 8'h00, 8'h00, 8'h00);
    check("failed decode output", sw_out[1], 1'b0);
  endtask

  // Fill the FIFO until it refuses, clear the overflow, drain in two fragments.
  task automatic t_fill(inout logic tog);
    logic [7:0] d;
    int i;
    for (i = 1; i <= 16; i++) push_byte(8'(i));
    @(negedge sys_clk);
    byte_valid = 1'b1;
    byte_data = 8'hEE;
    check("full FIFO refuses", byte_ready, 1'b0);
    @(negedge sys_clk);
    byte_valid = 1'b0;
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_RES_FLAGS, d);
    check("overflow flag", d[3], 1'b1);
    u_fbrio_ctl_model.write_img(8'h04, 8'h00, 1'b0);
    u_fbrio_ctl_model.write_img(8'h00, 8'h00, 1'b0);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_RES_FLAGS, d);
    check("overflow cleared", d[3], 1'b0);
    send_hdr(16'h0010, 1'b0);
    wait_pub(tog);
    check_frag(8'h00, 8'h01, 8'h0B, 8'h01);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_PAY_LAST, d);
    check("payload last", d, 8'h0B);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_RES_COUNT, d);
    check("result count after data reset", d, 8'h01);
    wait_pub(tog);
    check_frag(8'h01, 8'h00, 8'h05, 8'h0C);
    check("FIFO drained", byte_ready, 1'b1);
  endtask

  // Standby shows in the device state byte and holds off new results.
  task automatic t_standby();
    logic [7:0] d;
    // Let the last fragment's hold run out so that only standby can block headers.
    repeat (260) @(negedge sys_clk);
    u_fbrio_ctl_model.write_img(8'h10, 8'h00, 1'b0);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_DEV_STATE, d);
    check("standby state", d, 8'h01);
    check("header held off", hdr_ready, 1'b0);
    u_fbrio_ctl_model.write_img(8'h00, 8'h00, 1'b0);
    check("header taken again", hdr_ready, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic tog;
    logic [7:0] d;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    check("sw_out after reset", sw_out, 4'h0);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_XFER, d);
    check("handshake after reset", d, 8'h00);
    u_fbrio_ctl_model.read_img(fbrio_pkg::OFS_RES_FLAGS, d);
    tog = d[fbrio_pkg::FLAG_NEW_BIT];
    t_outputs();
    t_cmp();
    t_short(tog);
    t_fill(tog);
    t_standby();
    stop_test();
  end
endmodule
